//--- monitor_results_and_alert_flags_test.sv
// Self-checking bench for the monitor result and alert register bank.
// Assumes the design answers APB with one wait state and strobes on one clock.
`timescale 1ns/1ns
`default_nettype none
module monitor_results_and_alert_flags_test;
  import mra_pkg::*;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic [3:0] pstrb = 4'hf; // Only whole words are written.
  logic pready, pslverr, alert_out, alert_oe, active, e;
  logic meas_done = 0, meas_final = 0, math_overflow = 0, conv_start = 0, trim_error = 0;
  logic [2:0] sample_averaging_count = 3'h0;
  logic [14:0] rail_in = 0, rail_over_limit = 0, rail_under_limit = 0;
  logic [11:0] heat_in = 0, temp_limit = 0;
  logic [15:0] shunt_in = 0, current_in = 0, shunt_over_limit = 0, shunt_under_limit = 0;
  logic [23:0] power_in = 0, power_limit = 0;
  logic [5:0] v;
  int errors = 0;
  int check_count = 0;
  // Reference model state, kept as plain integers.
  int m_rail, m_heat, m_cur, m_pwr, m_ctl, m_lim, m_done, m_ovf;
  int m_trim = 1;

  // Free-running 50 MHz clock.
  always #10 clock = ~clock;

  mra_monitor_regs i_dut (.clock, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
    .prdata, .pready, .pslverr, .meas_done, .meas_final, .sample_averaging_count, .rail_in,
    .heat_in, .shunt_in, .current_in, .power_in, .temp_limit, .shunt_over_limit,
    .shunt_under_limit, .rail_over_limit, .rail_under_limit, .power_limit, .math_overflow,
    .conv_start, .trim_error, .alert_out, .alert_oe);

  // The watcher uses the polarity that the bench last wrote.
  mra_alert_watch i_watch (.alert_out, .alert_oe, .watt_over_flag(m_ctl[0]), .active);

  task automatic complete_run;
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : complete_run

  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t read %h expected %h", $time, got, exp);
    end
  endtask : chk_reg

  task automatic chk_bit(input logic got, input logic exp);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t bit %b expected %b", $time, got, exp);
    end
  endtask : chk_bit

  // One APB transfer; the request stands until pready is seen at an edge.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (n >= 16) begin
      errors++;
      $display("[ERR] %0t no bus answer", $time);
      complete_run();
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // An idle edge keeps the next request from touching psel in this step.
    @(posedge clock);
  endtask : apb

  task automatic rd_res;
    apb(1'b0, 8'h14, 32'h0);
    chk_reg(q, 32'(m_rail));
    apb(1'b0, 8'h18, 32'h0);
    chk_reg(q, 32'(m_heat));
    apb(1'b0, 8'h1c, 32'h0);
    chk_reg(q, 32'(m_cur));
    apb(1'b0, 8'h20, 32'h0);
    chk_reg(q, 32'(m_pwr));
  endtask : rd_res

  // Reading the diagnostic word clears latched flags after capture.
  task automatic rd_diag;
    apb(1'b0, 8'h2c, 32'h0);
    chk_reg(q, {16'h0, m_ctl[3:0], 2'b00, m_ovf[0], 1'b0, m_lim[5:0],
      m_done[0], m_trim[0]});
    chk_bit(e, 1'b0);
    if (m_ctl[3]) begin
      m_lim = 0;
      m_done = 0;
    end
  endtask : rd_diag

  // One random conversion strobe, then a model update and a pin check.
  task automatic step;
    logic fin;
    {rail_in, heat_in, shunt_in, current_in} <= 59'({$urandom, $urandom});
    {power_in, power_limit} <= 48'({$urandom, $urandom});
    {temp_limit, rail_over_limit, rail_under_limit} <= 42'({$urandom, $urandom});
    {shunt_over_limit, shunt_under_limit} <= $urandom;
    sample_averaging_count <= 3'($urandom % 2);
    meas_final <= 1'($urandom);
    math_overflow <= ($urandom % 4 == 0);
    conv_start <= ($urandom % 4 == 0);
    meas_done <= 1'b1;
    @(posedge clock);
    meas_done <= 1'b0;
    math_overflow <= 1'b0;
    conv_start <= 1'b0;
    fin = meas_final || sample_averaging_count == MRA_AVG_ONE;
    v = {$signed(heat_in) > $signed(temp_limit),
      $signed(shunt_in) > $signed(shunt_over_limit),
      $signed(shunt_in) < $signed(shunt_under_limit),
      rail_in > rail_over_limit, rail_in < rail_under_limit,
      power_in > power_limit};
    if (conv_start) begin
      m_done = 0;
      m_ovf = 0;
    end
    if (math_overflow) m_ovf = 1;
    if (fin) begin
      {m_rail, m_heat, m_cur, m_pwr} = {32'(rail_in), 32'({heat_in, 4'h0}),
        32'(current_in), 32'(power_in)};
      m_done = 1;
    end
    if (fin || !m_ctl[1]) m_lim = m_ctl[3] ? (m_lim | v) : v;
    repeat (3) @(posedge clock);
    chk_bit(active, (m_lim != 0) || (m_ctl[2] && m_done));
  endtask : step

  // Main sequence: reset values, random traffic in every mode, trim fault.
  initial begin
    void'($urandom(87));
    repeat (10) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    rd_res();
    rd_diag();
    apb(1'b0, 8'h24, 32'h0);
    chk_bit(e, 1'b1);
    $display("test reset values done");
    for (int c = 0; c < 16; c++) begin
      apb(1'b1, 8'h2c, {16'h0, c[3:0], 12'hfff});
      m_ctl = c;
      chk_bit(e, 1'b0);
      repeat (4) begin
        step();
        rd_res();
        rd_diag();
      end
    end
    $display("test random conversions done");
    apb(1'b1, 8'h14, 32'hffff_ffff);
    trim_error <= 1'b1;
    @(posedge clock);
    trim_error <= 1'b0;
    m_trim = 0;
    repeat (2) @(posedge clock);
    rd_res();
    rd_diag();
    $display("test trim and read-only writes done");
    // A second reset in mid-run must bring back every reset value.
    rst <= 1'b1;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    {m_rail, m_heat, m_cur, m_pwr, m_ctl, m_lim, m_done, m_ovf} = '0;
    m_trim = 1;
    rd_res();
    rd_diag();
    $display("test second reset done");
    complete_run();
  end
endmodule : monitor_results_and_alert_flags_test
`default_nettype wire

//--- mra_alert_watch.sv
// Partner model: watcher on the open-drain alert pin of the monitor block.
// Assumes a pull-up on the board, so a released pin reads high.
`timescale 1ns/1ns
`default_nettype none
module mra_alert_watch (
  input wire logic alert_out,
  input wire logic alert_oe,
  input wire logic watt_over_flag,
  output logic active
);
  // The pull-up wins whenever the device lets go of the pin.
  wire logic pin = alert_oe ? alert_out : 1'b1;
  // Normal polarity means a low pin is the active state.
  assign active = watt_over_flag ? pin : ~pin;
endmodule : mra_alert_watch
`default_nettype wire

//--- mra_monitor_regs.sv
// Result registers and diagnostic/alert register of the power monitor.
// Assumes the conversion engine and limit registers run on the same clock
// and hand over values with one-cycle strobes.
// The alert pin is an open drain: only its enable toggles, and a board
// pull-up sets the released level that the polarity bit relies on.
//
// Added by the designer: register access over APB.
`timescale 1ns/1ns
`default_nettype none
module mra_monitor_regs #(
  parameter int ADDR_W = 8
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic meas_done,
  input wire logic meas_final,
  input wire logic [2:0] sample_averaging_count,
  input wire logic [14:0] rail_in,
  input wire logic [11:0] heat_in,
  input wire logic [15:0] shunt_in,
  input wire logic [15:0] current_in,
  input wire logic [23:0] power_in,
  input wire logic [11:0] temp_limit,
  input wire logic [15:0] shunt_over_limit,
  input wire logic [15:0] shunt_under_limit,
  input wire logic [14:0] rail_over_limit,
  input wire logic [14:0] rail_under_limit,
  input wire logic [23:0] power_limit,
  input wire logic math_overflow,
  input wire logic conv_start,
  input wire logic trim_error,
  output logic alert_out,
  output logic alert_oe
);
  import mra_pkg::*;

  // The index decode needs address bits 5:2 at least.
  // A narrower bus could not tell the five registers apart.
  if (ADDR_W < 6) begin : g_chk
    $error("ADDR_W must be at least 6");
  end

  // Limit check of one set of readings; bit order is flags 7 down to 2.
  // Heat and shunt compare signed, rail and power unsigned, so a negative
  // limit on a signed reading trips the way the host expects.
  function automatic logic [5:0] mra_limits(
    input logic [11:0] heat,
    input logic [11:0] tlim,
    input logic [15:0] sh,
    input logic [15:0] shov,
    input logic [15:0] shun,
    input logic [14:0] rail,
    input logic [14:0] rov,
    input logic [14:0] run,
    input logic [23:0] pw,
    input logic [23:0] plim
  );
    logic [5:0] v;
    v[5] = $signed(heat) > $signed(tlim); // R12 R22
    v[4] = $signed(sh) > $signed(shov); // R13
    v[3] = $signed(sh) < $signed(shun); // R14
    v[2] = rail > rov; // R15
    v[1] = rail < run; // R16
    v[0] = pw > plim; // R17
    return v;
  endfunction : mra_limits

  mra_state_t state_reg; // Registered state of the whole block.
  mra_state_t state_next; // Next value of the state.

  logic [3:0] idx; // Word index of the current bus address.
  logic mapped; // The address hits one of the five registers.
  logic acc_done; // An APB access completes at this edge.
  logic rd_diag; // A read of the diagnostic register completes.
  logic final_res; // This strobe carries a finished result.
  logic cmp_evt; // Limit comparison happens at this edge.
  logic [5:0] viol; // Limits violated by the present readings.
  logic hold; // Latched alert mode is selected.
  logic [15:0] diag_word; // Read view of the diagnostic register.
  logic alert_act; // Alert condition, before polarity.

  // Address decode and event qualifiers.
  always_comb begin
    idx = paddr[5:2];
    mapped = 1'b0;
    if (paddr[ADDR_W-1:6] != '0) begin
      mapped = 1'b0;
    end else if (idx == MRA_IDX_RAIL || idx == MRA_IDX_HEAT) begin
      mapped = 1'b1;
    end else if (idx == MRA_IDX_CUR || idx == MRA_IDX_PWR) begin
      mapped = 1'b1;
    end else if (idx == MRA_IDX_DIAG) begin
      mapped = 1'b1;
    end
    acc_done = psel && penable && state_reg.pready;
    rd_diag = acc_done && !pwrite && mapped && idx == MRA_IDX_DIAG;
    // With averaging off, every sample is already a finished one.
    final_res = meas_done && (meas_final || sample_averaging_count == MRA_AVG_ONE);
    // Averaged compare waits for the finished value; raw takes each one.
    cmp_evt = state_reg.ctl[MRA_BIT_AVGCMP-12] ? final_res : meas_done; // R8
    viol = mra_limits(heat_in, temp_limit, shunt_in, shunt_over_limit,
                      shunt_under_limit, rail_in, rail_over_limit,
                      rail_under_limit, power_in, power_limit);
    hold = state_reg.ctl[MRA_BIT_HOLD-12];
  end

  // Read view; reserved bits 11:10 and 8 are constant zero.
  always_comb begin
    diag_word = 16'h0000; // R10
    diag_word[15:12] = state_reg.ctl;
    diag_word[MRA_BIT_OVF] = state_reg.ovf;
    diag_word[MRA_BIT_LIM_LO +: 6] = state_reg.lim;
    diag_word[MRA_BIT_DONE] = state_reg.done;
    diag_word[MRA_BIT_TRIM] = state_reg.trim_ok;
  end

  // Next-state logic for results, flags, bus answer and alert pin.
  always_comb begin
    state_next = state_reg;
    // Results load only from finished conversions.
    if (final_res) begin // R21
      state_next.rail = {1'b0, rail_in}; // R1
      state_next.heat = {heat_in, 4'h0}; // R2
      state_next.cur = current_in; // R3
      state_next.pwr = power_in; // R4
    end
    // Overflow: a new conversion clears, a fresh overflow wins.
    if (conv_start) begin
      state_next.ovf = 1'b0; // R11
    end
    if (math_overflow) begin
      state_next.ovf = 1'b1; // R11
    end
    // Limit flags. Only bits the host actually saw are cleared, so a
    // flag set between capture and completion is not lost.
    if (hold) begin
      if (rd_diag) begin
        state_next.lim = state_reg.lim & ~state_reg.prdata[MRA_BIT_LIM_LO +: 6]; // R18 R23
      end
      if (cmp_evt) begin
        state_next.lim = state_next.lim | viol; // R6
      end
    end else if (cmp_evt) begin
      // Transparent flags follow the latest comparison.
      state_next.lim = viol; // R5
    end
    // Done flag; setting beats the read and conversion clears in the same cycle.
    if (hold && rd_diag && state_reg.prdata[MRA_BIT_DONE]) begin
      state_next.done = 1'b0; // R19 R23
    end
    if (conv_start) begin
      state_next.done = 1'b0; // R19
    end
    if (final_res) begin
      state_next.done = 1'b1; // R19
    end
    // Trim status never recovers without a reset.
    if (trim_error) begin
      state_next.trim_ok = 1'b0; // R20
    end
    // Control bits are the only writable field (byte lane 1).
    if (acc_done && pwrite && mapped && idx == MRA_IDX_DIAG && pstrb[1]) begin
      state_next.ctl = pwdata[15:12]; // R10
    end
    // APB: one wait state; data is captured as pready rises.
    // The wait state lets the read mux land in a register, so prdata is a
    // clean flop output; the price is one extra cycle per transfer.
    state_next.pready = 1'b0;
    state_next.pslverr = 1'b0;
    if (psel && penable && !state_reg.pready) begin
      state_next.pready = 1'b1;
      state_next.pslverr = !mapped;
      state_next.prdata = 32'h00000000;
      if (pwrite || !mapped) begin
        state_next.prdata = 32'h00000000;
      end else if (idx == MRA_IDX_RAIL) begin
        state_next.prdata = {16'h0000, state_reg.rail}; // R1
      end else if (idx == MRA_IDX_HEAT) begin
        state_next.prdata = {16'h0000, state_reg.heat}; // R2
      end else if (idx == MRA_IDX_CUR) begin
        state_next.prdata = {16'h0000, state_reg.cur}; // R3
      end else if (idx == MRA_IDX_PWR) begin
        state_next.prdata = {8'h00, state_reg.pwr}; // R4
      end else begin
        state_next.prdata = {16'h0000, diag_word};
      end
    end
    // Alert pin: limit flags, plus done when routed to the pin.
    // The done flag alone raises the pin only with the routing bit set.
    alert_act = (state_reg.lim != 6'h00) ||
                (state_reg.ctl[MRA_BIT_RDYPIN-12] && state_reg.done); // R7
    // Open drain can only pull low: active-low pulls while active,
    // active-high pulls while idle.
    state_next.alert_oe = alert_act ^ state_reg.ctl[MRA_BIT_POL-12]; // R9
    // Reset comes last, so it beats every event and bus access in the
    // same cycle; the result, control and trim values are package constants.
    if (rst) begin
      state_next.rail = MRA_RES_RST;
      state_next.heat = MRA_RES_RST;
      state_next.cur = MRA_RES_RST;
      state_next.pwr = MRA_PWR_RST;
      state_next.ctl = MRA_CTL_RST;
      state_next.ovf = 1'b0;
      state_next.lim = 6'h00;
      state_next.done = 1'b0;
      state_next.trim_ok = MRA_TRIM_RST; // R20
      state_next.pready = 1'b0;
      state_next.pslverr = 1'b0;
      state_next.prdata = 32'h00000000;
      state_next.alert_oe = 1'b0;
    end
  end

  // Single state register; reset is folded into the next value.
  // The state is unknown until the first edge with rst high.
  always_ff @(posedge clock) begin
    state_reg <= state_next;
  end

  // Outputs straight from the state flip-flops; the pin level is always 0.
  assign prdata = state_reg.prdata;
  assign pready = state_reg.pready;
  assign pslverr = state_reg.pslverr;
  assign alert_oe = state_reg.alert_oe;
  assign alert_out = 1'b0;

  // Checks on the block's own behaviour.
  // They watch the state flip-flops and the bus pins, and rest while reset
  // is high, so reset values are checked at the first edge after it.
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  // A finished result strobe; each property checks the load at the next edge.
  sequence s_final;
    meas_done && (meas_final || sample_averaging_count == MRA_AVG_ONE);
  endsequence

  a_rail_loads: assert property (s_final |=> // R1
    state_reg.rail == {1'b0, $past(rail_in)})
    else $error("rail result not loaded from finished sample");
  a_heat_nibble: assert property (s_final |=> // R2
    state_reg.heat[3:0] == 4'h0 && state_reg.heat[15:4] == $past(heat_in))
    else $error("heat result misplaced");
  a_avg_hold: assert property ( // R21
    meas_done && !meas_final && sample_averaging_count != MRA_AVG_ONE
    |=> $stable(state_reg.pwr) && $stable(state_reg.cur))
    else $error("result changed before averaging finished");
  a_trans_follow: assert property (!hold && cmp_evt |=> // R5
    state_reg.lim == $past(viol))
    else $error("transparent flags do not follow compare");
  a_latch_keep: assert property ( // R6
    hold && state_reg.lim != 6'h00 && !rd_diag && !$fell(hold)
    |=> state_reg.lim != 6'h00)
    else $error("latched flag dropped without read");
  a_read_clear: assert property (hold && rd_diag && !cmp_evt |=> // R18
    (state_reg.lim & $past(state_reg.prdata[7:2])) == 6'h00)
    else $error("read did not clear seen flags");
  a_rdy_pin: assert property ( // R7
    state_reg.ctl[MRA_BIT_RDYPIN-12] && state_reg.done && !$changed(state_reg.ctl)
    |=> alert_oe == !$past(state_reg.ctl[MRA_BIT_POL-12]))
    else $error("done flag not routed to alert pin");
  a_pol_idle: assert property ( // R9
    state_reg.lim == 6'h00 && !state_reg.done && $stable(state_reg.ctl) [*2]
    |-> alert_oe == state_reg.ctl[MRA_BIT_POL-12])
    else $error("idle alert level wrong for polarity");
  a_ovf_clear: assert property (conv_start && !math_overflow |=> // R11
    !state_reg.ovf)
    else $error("overflow not cleared by conversion");
  a_trim_fall: assert property ($fell(state_reg.trim_ok) |-> // R20
    $past(trim_error))
    else $error("trim status fell without error");
  a_rsvd_zero: assert property ( // R10
    pready && !pslverr && $past(idx) == MRA_IDX_DIAG && $past(!pwrite)
    |-> prdata[11:10] == 2'h0 && !prdata[8])
    else $error("reserved bits read nonzero");
  a_apb_wait: assert property (psel && penable && !pready |=> pready ##1 !pready)
    else $error("APB answer not one wait state");

  // Host steps and one unfinished sample, each seen at one edge. Each keeps
  // the events that could move the checked flags out of its cycle, so only
  // its own event can explain what the flags do at the next edge.

  // A quiet write to the diagnostic word with the control lane enabled.
  sequence s_diag_write;
    psel && penable && pready && pwrite && pstrb[1] &&
      paddr[5:2] == MRA_IDX_DIAG && paddr[ADDR_W-1:6] == '0 &&
      !meas_done && !conv_start && !math_overflow && !trim_error;
  endsequence

  // A latched-mode read of the diagnostic word that returned done.
  sequence s_done_read;
    psel && penable && pready && !pwrite &&
      paddr[5:2] == MRA_IDX_DIAG && paddr[ADDR_W-1:6] == '0 &&
      state_reg.ctl[MRA_BIT_HOLD-12] && prdata[MRA_BIT_DONE] && !meas_done;
  endsequence

  // An unfinished sample while compares wait for the averaged value.
  sequence s_avg_skip;
    state_reg.ctl[MRA_BIT_AVGCMP-12] && meas_done && !meas_final &&
      sample_averaging_count != MRA_AVG_ONE && !(psel && penable && pready);
  endsequence

  // Control bits take the written value; the flags do not move.
  a_ctl_write: assert property (s_diag_write |=> // R9
    state_reg.ctl == $past(pwdata[15:12]))
    else $error("control bits not written");
  a_flags_ro: assert property (s_diag_write |=> // R10
    $stable(state_reg.lim) && $stable(state_reg.ovf) && $stable(state_reg.done))
    else $error("host write changed a flag");

  // Result words load whole from a finished sample.
  a_cur_load: assert property (s_final |=> // R3
    state_reg.cur == $past(current_in))
    else $error("current result not loaded");
  a_pwr_load: assert property (s_final |=> // R4
    state_reg.pwr == $past(power_in))
    else $error("power result not loaded");

  // Overflow is sticky until the next conversion starts.
  a_ovf_set: assert property (math_overflow |=> state_reg.ovf) // R11
    else $error("overflow flag not set");
  a_ovf_keep: assert property (state_reg.ovf && !conv_start |=> state_reg.ovf) // R11
    else $error("overflow flag dropped early");

  // Done flag: set by a finished sample, cleared by a latched read.
  a_done_set: assert property (s_final |=> state_reg.done) // R19
    else $error("done flag not set");
  a_done_read: assert property (s_done_read |=> !state_reg.done) // R19
    else $error("done flag kept after read");

  // In transparent mode only a new conversion drops the done flag.
  a_done_keep: assert property ( // R19
    !state_reg.ctl[MRA_BIT_HOLD-12] && state_reg.done && !conv_start
    |=> state_reg.done)
    else $error("done flag dropped in transparent mode");

  // Trim status: one out of reset, then sticky at zero.
  a_trim_reset: assert property ($fell(rst) |-> state_reg.trim_ok) // R20
    else $error("trim status not one after reset");
  a_trim_sticky: assert property (!state_reg.trim_ok |=> !state_reg.trim_ok) // R20
    else $error("trim status recovered");

  // Results and flags start from zero after a reset.
  a_res_zero: assert property ($fell(rst) |-> // R1
    state_reg.rail == MRA_RES_RST && state_reg.pwr == MRA_PWR_RST &&
    state_reg.lim == 6'h00)
    else $error("result or flag not cleared by reset");

  // Latched flags gain every violation found by a compare.
  a_latch_set: assert property ( // R6
    state_reg.ctl[MRA_BIT_HOLD-12] && cmp_evt
    |=> (state_reg.lim & $past(viol)) == $past(viol))
    else $error("latched flag missed a violation");

  // Any raised limit flag drives the pin to its active level.
  a_pin_active: assert property (state_reg.lim != 6'h00 |=> // R6
    alert_oe == !$past(state_reg.ctl[MRA_BIT_POL-12]))
    else $error("alert pin idle while a flag is up");

  // Without routing, the done flag leaves the pin at its idle level.
  a_rdy_off: assert property ( // R7
    !state_reg.ctl[MRA_BIT_RDYPIN-12] && state_reg.lim == 6'h00
    |=> alert_oe == $past(state_reg.ctl[MRA_BIT_POL-12]))
    else $error("done flag reached pin while not routed");

  // With averaged compare, unfinished samples leave the flags alone.
  a_raw_skip: assert property (s_avg_skip |=> $stable(state_reg.lim)) // R8
    else $error("flags moved on an unfinished sample");

  // A refused access answers with zero data.
  a_err_data: assert property (pslverr |-> pready && prdata == 32'h00000000)
    else $error("refused access returned data");
endmodule : mra_monitor_regs
`default_nettype wire

//--- mra_pkg.sv
// Constants, types and register map of the monitor result and alert block.
// Assumes a 32-bit APB master; register index times four is the byte address.
// Overview of operation
// (R1) Rail reading read-only, never negative.
// (R2) Heat reading in 15:4, low nibble zero.
// (R3) Current result read-only signed word.
// (R4) Power result read-only unsigned 24 bits.
// (R5) Transparent mode: alert follows fault condition.
// (R6) Latched mode: alert holds until diagnostic read.
// (R7) Ready-to-pin enable routes done flag to alert.
// (R8) Compare on raw or averaged results.
// (R9) Polarity bit selects alert active level.
// (R10) Reserved bits read zero, not writable.
// (R11) Overflow flag clears on next conversion.
// (R12) Heat above limit sets temp flag.
// (R13) Shunt above limit sets sense-over flag.
// (R14) Shunt below limit sets sense-under flag.
// (R15) Rail above limit sets rail-over flag.
// (R16) Rail below limit sets rail-under flag.
// (R17) Power above limit sets watt flag.
// (R18) Latched limit flags clear on diagnostic read.
// (R19) Done flag sets on completion, clears.
// (R20) Trim checksum bit resets one, error clears.
// (R21) Averaging: results update only when complete.
// (R22) Heat limit compares directly, same scaling.
// (R23) Read clear happens after data capture.
package mra_pkg;
  // Register indices; byte address is four times the index.
  localparam logic [3:0] MRA_IDX_RAIL = 4'h5;
  localparam logic [3:0] MRA_IDX_HEAT = 4'h6;
  localparam logic [3:0] MRA_IDX_CUR = 4'h7;
  localparam logic [3:0] MRA_IDX_PWR = 4'h8;
  localparam logic [3:0] MRA_IDX_DIAG = 4'hb;
  // Diagnostic register field positions.
  localparam int MRA_BIT_HOLD = 15;
  localparam int MRA_BIT_RDYPIN = 14;
  localparam int MRA_BIT_AVGCMP = 13;
  localparam int MRA_BIT_POL = 12;
  localparam int MRA_BIT_OVF = 9;
  localparam int MRA_BIT_LIM_LO = 2;
  localparam int MRA_BIT_DONE = 1;
  localparam int MRA_BIT_TRIM = 0;
  // Values after reset.
  localparam logic [3:0] MRA_CTL_RST = 4'h0;
  localparam logic MRA_TRIM_RST = 1'b1;
  localparam logic [15:0] MRA_RES_RST = 16'h0000;
  localparam logic [23:0] MRA_PWR_RST = 24'h000000;
  // Averaging count code for a single sample.
  localparam logic [2:0] MRA_AVG_ONE = 3'h0;

  // Whole state of the block.
  typedef struct packed {
    logic [15:0] rail;
    logic [15:0] heat;
    logic [15:0] cur;
    logic [23:0] pwr;
    logic [3:0] ctl;
    logic ovf;
    logic [5:0] lim;
    logic done;
    logic trim_ok;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic alert_oe;
  } mra_state_t;
endpackage : mra_pkg
